// ===== inc/sbc_pkg.sv
// Constants, field helpers and register map of the SDRAM bank configuration block
package sbc_pkg;
  localparam int unsigned NBANK = 2;
  localparam logic [31:0] ADDR_BANK0 = 32'hB000_1008;
  localparam logic [31:0] ADDR_BANK1 = 32'hB000_100C;
  localparam logic [31:0] ADDR_REFRESH = 32'hB000_1040;
  localparam logic [31:0] ADDR_STATUS = 32'hB000_1044;
  localparam logic [31:0] CFG_RESET = 32'h0000_0800;
  localparam logic [31:0] CFG_WMASK = 32'hFFF8_B8FF;
  localparam logic [31:0] REF_RESET = 32'h0000_0000;
  localparam logic [31:0] REF_WMASK = 32'h0000_FFFB;
  localparam int BASE_LSB = 19;
  localparam int BASE_W = 13;
  localparam int BASE_SHIFT = 18;
  localparam int MRS_BIT = 15;
  localparam int APR_BIT = 13;
  localparam int LAT_LSB = 11;
  localparam int CBK_BIT = 7;
  localparam int DBW_LSB = 5;
  localparam int COL_LSB = 3;
  localparam int SIZE_LSB = 0;
  localparam int SIZE_UNIT_LOG2 = 20;
  localparam int COL_MIN = 8;
  localparam int REF_CNT_LSB = 3;
  localparam int REF_EN_LSB = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic [2:0] f_size(input logic [31:0] c);
    return c[SIZE_LSB +: 3];
  endfunction
  function automatic logic [1:0] f_dbw(input logic [31:0] c);
    return c[DBW_LSB +: 2];
  endfunction
  function automatic logic [1:0] f_col(input logic [31:0] c);
    return c[COL_LSB +: 2];
  endfunction
  function automatic logic [32:0] bank_start(input logic [31:0] c);
    return 33'(c[BASE_LSB +: BASE_W]) << BASE_SHIFT;
  endfunction
  function automatic logic [32:0] bank_span(input logic [31:0] c);
    return 33'h1 << (SIZE_UNIT_LOG2 + int'(f_size(c)));
  endfunction
  function automatic logic bank_on(input logic [31:0] c);
    return (f_size(c) != 3'h0) && (f_dbw(c) != 2'h0);
  endfunction
  // Reserved latency code is run at the longest latency
  function automatic logic [1:0] cas_cycles(input logic [31:0] c);
    return (c[LAT_LSB +: 2] == 2'h3) ? 2'h3 : 2'(c[LAT_LSB +: 2] + 2'h1);
  endfunction
  function automatic logic [31:0] apply_write(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        r[8*b +: 8] = d[8*b +: 8] & mask[8*b +: 8];
    return r;
  endfunction
endpackage

// ===== rtl/sbc_decode.sv
// Address decode and row/column split for one SDRAM bank
`timescale 1ns/1ps
`default_nettype none
module sbc_decode
  import sbc_pkg::*;
#(
  parameter int ROW_W = 13,
  parameter int COL_W = 11
)(
  input  wire logic [31:0]      cfg,
  input  wire logic [31:0]      addr,
  output logic                  hit,
  output logic [ROW_W-1:0]      row,
  output logic [COL_W-1:0]      col,
  output logic [1:0]            ibank
);
  logic [32:0] off;
  logic [31:0] word;
  int          cbits;
  int          shift;

  always_comb
  begin
    off = {1'b0, addr} - bank_start(cfg); // RQ2
    hit = bank_on(cfg) && ({1'b0, addr} >= bank_start(cfg)) && (off < bank_span(cfg)); // RQ3 RQ9 RQ11
    shift = (f_dbw(cfg) == 2'h0) ? 0 : int'(f_dbw(cfg)) - 1; // RQ8
    word = off[31:0] >> shift;
    cbits = COL_MIN + int'(f_col(cfg)); // RQ10
    col = COL_W'(word & ((32'h1 << cbits) - 32'h1)); // RQ10
    ibank = 2'(word >> cbits) & {cfg[CBK_BIT], 1'b1}; // RQ7
    row = ROW_W'(word >> (cbits + 1 + int'(cfg[CBK_BIT]))); // RQ7
  end
endmodule // sbc_decode
`default_nettype wire

// ===== rtl/sbc_refresh.sv
// Shared refresh period timer issuing per-bank refresh strobes
`timescale 1ns/1ps
`default_nettype none
module sbc_refresh
  import sbc_pkg::*;
#(
  parameter int CNT_W = 13
)(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [CNT_W-1:0] period,
  input  wire logic [1:0]       enable,
  output logic [1:0]            refresh_cmd
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [1:0]       cmd;
  } sbc_ref_t;

  sbc_ref_t st;
  sbc_ref_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.cmd = 2'h0;
    if (enable == 2'h0 || period == '0)
      next_st.cnt = '0;
    else if (st.cnt >= period - 1'b1)
    begin
      next_st.cnt = '0;
      next_st.cmd = enable; // RQ12
    end
    else
      next_st.cnt = st.cnt + 1'b1; // RQ12
    if (!aresetn)
      next_st = '0;
  end

  always_ff @(posedge aclk)
    st <= next_st;

  assign refresh_cmd = st.cmd;

  logic [CNT_W:0]   gap;
  logic [CNT_W-1:0] prev_period;
  logic             seen;

  always_ff @(posedge aclk)
  begin
    prev_period <= period;
    if (!aresetn || period != prev_period || enable == 2'h0)
    begin
      seen <= 1'b0;
      gap <= '0;
    end
    else if (st.cmd != 2'h0)
    begin
      seen <= 1'b1;
      gap <= (CNT_W+1)'(1);
    end
    else
      gap <= gap + 1'b1;
  end

  a_refresh_period: assert property (@(posedge aclk) disable iff (!aresetn) // RQ12
    (st.cmd != 2'h0) && seen && (period == prev_period) |-> gap == {1'b0, period})
    else $error("refresh strobe spacing differs from the programmed count");
endmodule // sbc_refresh
`default_nettype wire

// ===== rtl/sbc_top.sv
// SDRAM bank configuration registers, bank decode and command triggers
// Function
// RQ1 - Each of the two banks has its own configuration register and works from it alone.
// RQ2 - A bank starts at its 13-bit base pointer field shifted left by 18.
// RQ3 - An access hits a bank when it lies between its start and start plus its size.
// RQ4 - Setting the mode trigger bit issues a mode register set command to that bank.
// RQ5 - Auto pre-charge bit 0 selects auto pre-charge, 1 selects none.
// RQ6 - The latency field gives one, two or three clocks, the last code reserved.
// RQ7 - The bank count bit selects two or four internal banks.
// RQ8 - The width field selects disabled, 8, 16 or 32 bit data.
// RQ9 - A disabled width field keeps that bank's chip select inactive.
// RQ10 - The column field gives 8 to 11 column bits for the row and column split.
// RQ11 - The size field gives disabled or 2M to 128M bytes, doubling per step.
// RQ12 - Each bank with refresh enabled gets an auto refresh every refresh count clocks.
// RQ13 - The mode command goes out only while the bank is idle and then clears the trigger.
`timescale 1ns/1ps
`default_nettype none
module sbc_top
  import sbc_pkg::*;
#(
  parameter int ROW_W = 13,
  parameter int COL_W = 11,
  parameter int REF_W = 13
)(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [31:0]      s_axi_awaddr,
  input  wire logic [2:0]       s_axi_awprot,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [31:0]      s_axi_araddr,
  input  wire logic [2:0]       s_axi_arprot,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic             mem_req,
  input  wire logic [31:0]      mem_addr,
  input  wire logic [1:0]       bank_idle,
  output logic [1:0]            mem_cs_n,
  output logic [ROW_W-1:0]      mem_row,
  output logic [COL_W-1:0]      mem_col,
  output logic [1:0]            mem_ibank,
  output logic [1:0]            mem_cas_cycles,
  output logic                  mem_auto_precharge,
  output logic [1:0]            mem_bus_width,
  output logic [1:0]            mode_set_cmd,
  output logic [1:0]            refresh_cmd
);
  typedef struct packed {
    logic                   aw_held;
    logic [31:0]            aw_addr;
    logic                   w_held;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic [NBANK-1:0][31:0] cfg;
    logic [31:0]            refctl;
    logic [1:0]             cs_n;
    logic [ROW_W-1:0]       row;
    logic [COL_W-1:0]       col;
    logic [1:0]             ibank;
    logic [1:0]             cl;
    logic                   apr;
    logic [1:0]             width;
    logic [1:0]             mrs;
  } sbc_state_t;

  sbc_state_t st;
  sbc_state_t next_st;

  logic [NBANK-1:0]            hit;
  logic [NBANK-1:0][ROW_W-1:0] row_d;
  logic [NBANK-1:0][COL_W-1:0] col_d;
  logic [NBANK-1:0][1:0]       ibank_d;
  logic                        wr_fire;
  logic                        wr_bank0;
  logic                        sel;

  // One decoder per bank so that each runs from its own settings
  for (genvar i = 0; i < NBANK; i++)
  begin : g_dec
    sbc_decode #(
      .ROW_W (ROW_W),
      .COL_W (COL_W)
    ) u_dec (
      .cfg   (st.cfg[i]),
      .addr  (mem_addr),
      .hit   (hit[i]),
      .row   (row_d[i]),
      .col   (col_d[i]),
      .ibank (ibank_d[i])
    );
  end

  sbc_refresh #(
    .CNT_W (REF_W)
  ) u_ref (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .period      (st.refctl[REF_CNT_LSB +: REF_W]),
    .enable      (st.refctl[REF_EN_LSB +: 2]),
    .refresh_cmd (refresh_cmd)
  );

  assign wr_fire = st.aw_held && st.w_held && !st.bvalid;
  assign wr_bank0 = wr_fire && (st.aw_addr == ADDR_BANK0);
  // Bank 0 wins if software lets the two windows overlap
  assign sel = !hit[0];

  assign s_axi_awready = !st.aw_held;
  assign s_axi_wready = !st.w_held;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;

  assign mem_cs_n = st.cs_n;
  assign mem_row = st.row;
  assign mem_col = st.col;
  assign mem_ibank = st.ibank;
  assign mem_cas_cycles = st.cl;
  assign mem_auto_precharge = st.apr;
  assign mem_bus_width = st.width;
  assign mode_set_cmd = st.mrs;

  always_comb
  begin
    next_st = st;
    if (s_axi_awvalid && !st.aw_held)
    begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_held)
    begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;
    if (st.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;

    // Trigger is consumed only on an idle bank; a write in the same cycle wins
    for (int i = 0; i < NBANK; i++)
    begin
      next_st.mrs[i] = st.cfg[i][MRS_BIT] && bank_idle[i]; // RQ4 RQ13
      if (next_st.mrs[i])
        next_st.cfg[i][MRS_BIT] = 1'b0; // RQ13
    end

    if (wr_fire)
    begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      unique case (st.aw_addr)
        ADDR_BANK0:
          next_st.cfg[0] = apply_write(next_st.cfg[0], st.w_data, st.w_strb, CFG_WMASK); // RQ1
        ADDR_BANK1:
          next_st.cfg[1] = apply_write(next_st.cfg[1], st.w_data, st.w_strb, CFG_WMASK); // RQ1
        ADDR_REFRESH:
          next_st.refctl = apply_write(st.refctl, st.w_data, st.w_strb, REF_WMASK);
        default:
          next_st.bresp = RESP_SLVERR;
      endcase
    end

    if (s_axi_arvalid && !st.rvalid)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_BANK0:
          next_st.rdata = st.cfg[0];
        ADDR_BANK1:
          next_st.rdata = st.cfg[1];
        ADDR_REFRESH:
          next_st.rdata = st.refctl;
        ADDR_STATUS:
          next_st.rdata = {28'h0, bank_on(st.cfg[1]), bank_on(st.cfg[0]),
                           st.cfg[1][MRS_BIT], st.cfg[0][MRS_BIT]};
        default:
        begin
          next_st.rdata = 32'h0;
          next_st.rresp = RESP_SLVERR;
        end
      endcase
    end

    // Chip select only from a decoder hit, which already excludes a disabled bank
    next_st.cs_n = 2'h3;
    if (mem_req && (hit != 2'h0))
    begin
      next_st.cs_n[sel] = 1'b0; // RQ3 RQ9
      next_st.row = row_d[sel]; // RQ10
      next_st.col = col_d[sel]; // RQ10
      next_st.ibank = ibank_d[sel]; // RQ7
      next_st.cl = cas_cycles(st.cfg[sel]); // RQ6
      next_st.apr = !st.cfg[sel][APR_BIT]; // RQ5
      next_st.width = f_dbw(st.cfg[sel]); // RQ8
    end

    if (!aresetn)
    begin
      next_st = '0;
      next_st.cfg = {CFG_RESET, CFG_RESET};
      next_st.refctl = REF_RESET;
      next_st.cs_n = 2'h3;
    end
  end

  always_ff @(posedge aclk)
    st <= next_st;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_bank_indep: assert property ( // RQ1
    $past(wr_bank0) |-> $stable(st.cfg[1]))
    else $error("bank 1 settings moved on a bank 0 write");

  a_base_shift: assert property ( // RQ2
    mem_req && bank_on(st.cfg[0]) && ({1'b0, mem_addr} == bank_start(st.cfg[0]))
    |=> !st.cs_n[0])
    else $error("bank 0 start address not selected");

  a_cs_range: assert property ( // RQ3
    !st.cs_n[1] |-> ({1'b0, $past(mem_addr)} >= bank_start($past(st.cfg[1])))
      && ({1'b0, $past(mem_addr)} - bank_start($past(st.cfg[1])) < bank_span($past(st.cfg[1]))))
    else $error("bank 1 selected outside its range");

  a_mrs_issue: assert property ( // RQ4
    st.cfg[0][MRS_BIT] && bank_idle[0] |=> st.mrs[0] ##1 (!st.mrs[0] || $past(wr_fire, 2)))
    else $error("mode set trigger not turned into one command");

  a_precharge: assert property ( // RQ5
    !st.cs_n[0] |-> st.apr == !$past(st.cfg[0][APR_BIT]))
    else $error("auto pre-charge select inverted");

  a_cas_cycles: assert property ( // RQ6
    !st.cs_n[0] && ($past(st.cfg[0][LAT_LSB +: 2]) != 2'h3)
    |-> st.cl == 2'($past(st.cfg[0][LAT_LSB +: 2]) + 2'h1))
    else $error("CAS latency count wrong");

  a_two_banks: assert property ( // RQ7
    !st.cs_n[0] && !$past(st.cfg[0][CBK_BIT]) |-> !st.ibank[1])
    else $error("internal bank above one with two banks");

  a_bus_width: assert property ( // RQ8
    !st.cs_n[1] && $past(st.cs_n[0]) |-> st.width == $past(st.cfg[1][DBW_LSB +: 2]))
    else $error("bus width not taken from the bank");

  a_cs_disabled: assert property ( // RQ9
    !st.cs_n[0] |-> f_dbw($past(st.cfg[0])) != 2'h0)
    else $error("chip select on a disabled bank");

  a_col_width: assert property ( // RQ10
    !st.cs_n[0] |-> 32'(st.col) < (32'h1 << (COL_MIN + int'($past(st.cfg[0][COL_LSB +: 2])))))
    else $error("column wider than programmed");

  a_size_top: assert property ( // RQ11
    mem_req && bank_on(st.cfg[0])
      && ({1'b0, mem_addr} == bank_start(st.cfg[0]) + bank_span(st.cfg[0]))
    |=> st.cs_n[0])
    else $error("bank 0 selected past its size");

  a_mrs_idle: assert property ( // RQ13
    st.mrs[1] |-> $past(bank_idle[1]) && ($past(wr_fire) || !st.cfg[1][MRS_BIT]))
    else $error("mode command while busy or trigger kept");
endmodule // sbc_top
`default_nettype wire

// ===== tb/sbc_sdram_model.sv
// Behavioural SDRAM devices on the far side: idle flags and command counters
`timescale 1ns/1ps
`default_nettype none
module sbc_sdram_model
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [1:0] stall,
  input  wire logic [1:0] mem_cs_n,
  input  wire logic [1:0] mode_set_cmd,
  input  wire logic [1:0] refresh_cmd,
  output logic [1:0]      bank_idle,
  output int              mode0,
  output int              mode1,
  output int              ref1,
  output int              gap
);
  int since;
  // Busy while stalled or while its chip select is active
  assign bank_idle = ~stall & mem_cs_n;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode0 <= 0;
      mode1 <= 0;
      ref1  <= 0;
      gap   <= 0;
      since <= 0;
    end
    else
    begin
      mode0 <= mode0 + int'(mode_set_cmd[0]);
      mode1 <= mode1 + int'(mode_set_cmd[1]);
      ref1  <= ref1 + int'(refresh_cmd[1]);
      since <= refresh_cmd[0] ? 1 : since + 1;
      if (refresh_cmd[0])
        gap <= since;
    end
  end
endmodule // sbc_sdram_model
`default_nettype wire

// ===== tb/sbc_top_tb.sv
// Self-checking bench for the SDRAM bank configuration block
`timescale 1ns/1ps
`default_nettype none
module sbc_top_tb
  import sbc_pkg::*;
;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, mem_req;
  logic        awready, wready, bvalid, arready, rvalid, apr;
  logic [31:0] awaddr, wdata, araddr, rdata, mem_addr;
  logic [1:0]  bresp, rresp, stall, idle, cs_n, ibank, cas, bw, mset, rcmd;
  logic [12:0] row;
  logic [10:0] col;
  logic [31:0] cfg [2];
  logic [31:0] baddr [2];
  logic [31:0] d, a;
  logic [1:0]  r;
  int          miscompares, check_count, cyc, mode0, mode1, ref1, gap, n;

  sbc_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mem_req(mem_req), .mem_addr(mem_addr), .bank_idle(idle), .mem_cs_n(cs_n),
    .mem_row(row), .mem_col(col), .mem_ibank(ibank), .mem_cas_cycles(cas),
    .mem_auto_precharge(apr), .mem_bus_width(bw), .mode_set_cmd(mset), .refresh_cmd(rcmd));
  sbc_sdram_model u_mem (.aclk(aclk), .aresetn(aresetn), .stall(stall), .mem_cs_n(cs_n),
    .mode_set_cmd(mset), .refresh_cmd(rcmd), .bank_idle(idle), .mode0(mode0),
    .mode1(mode1), .ref1(ref1), .gap(gap));

  always #50 aclk = ~aclk;

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Generous ceiling; the whole sequence needs under two thousand cycles
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      miscompares++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Ready is sampled mid-cycle so release lands right after the taking edge
  task automatic axw(input logic [31:0] ad, input logic [31:0] dt, input logic [1:0] er);
    logic done, ta, tw;
    done = 0;
    @(posedge aclk);
    awaddr <= ad;
    wdata <= dt;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!done)
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      done = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta)
        awvalid <= 0;
      if (tw)
        wvalid <= 0;
    end
    bready <= 0;
    chk("bresp", 32'(er), 32'(r));
  endtask

  task automatic axr(input logic [31:0] ad, input logic [31:0] ed, input logic [1:0] er);
    logic done, ta;
    done = 0;
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1;
    rready <= 1;
    while (!done)
    begin
      @(negedge aclk);
      ta = arvalid && arready;
      done = rvalid;
      r = rresp;
      d = rdata;
      @(posedge aclk);
      if (ta)
        arvalid <= 0;
    end
    rready <= 0;
    chk("rresp", 32'(er), 32'(r));
    chk("rdata", ed, d);
  endtask

  task automatic mem_chk(input logic [31:0] ad);
    longint st, w;
    logic [31:0] c;
    int b, cb, ib;
    logic [1:0] ecs;
    b = -1;
    ecs = 2'h3;
    for (int i = 1; i >= 0; i--)
    begin
      c = cfg[i];
      st = longint'(c[31:19]) << 18;
      if (c[2:0] != 0 && c[6:5] != 0 && ad >= st && ad < st + (longint'(1) << (20 + c[2:0])))
        b = i;
    end
    if (b >= 0)
      ecs[b] = 0;
    @(posedge aclk);
    mem_req <= 1;
    mem_addr <= ad;
    @(posedge aclk);
    @(negedge aclk);
    chk("cs_n", 32'(ecs), 32'(cs_n));
    if (b >= 0)
    begin
      c = cfg[b];
      w = (longint'(ad) - (longint'(c[31:19]) << 18)) >> (c[6:5] - 1);
      cb = 8 + c[4:3];
      ib = c[7] ? 2 : 1;
      chk("col", 32'(w & ((longint'(1) << cb) - 1)), 32'(col));
      chk("ibank", 32'((w >> cb) & ((1 << ib) - 1)), 32'(ibank));
      chk("row", 32'((w >> (cb + ib)) & 32'h1FFF), 32'(row));
      chk("cas", (c[12:11] == 3) ? 3 : c[12:11] + 1, 32'(cas));
      chk("apr", 32'(!c[13]), 32'(apr));
      chk("width", 32'(c[6:5]), 32'(bw));
    end
  endtask

  initial
  begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, mem_req} = 0;
    {awaddr, wdata, araddr, mem_addr, stall} = 0;
    baddr[0] = ADDR_BANK0;
    baddr[1] = ADDR_BANK1;
    void'($urandom(55));
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    cfg[0] = CFG_RESET;
    cfg[1] = CFG_RESET;
    axr(ADDR_BANK0, CFG_RESET, RESP_OKAY);
    axr(ADDR_BANK1, CFG_RESET, RESP_OKAY);
    axr(ADDR_REFRESH, REF_RESET, RESP_OKAY);
    axr(ADDR_BANK0 + 32'h0000_0100, 32'h0, RESP_SLVERR);
    axw(ADDR_STATUS, 32'h0000_000F, RESP_SLVERR);
    $display("test reset_map done");
    for (int k = 0; k < 4; k++)
    begin
      d = $urandom() & 32'hFFFF_7FFF;
      axw(baddr[k % 2], d, RESP_OKAY);
      cfg[k % 2] = d & CFG_WMASK;
      axr(ADDR_BANK0, cfg[0], RESP_OKAY);
      axr(ADDR_BANK1, cfg[1], RESP_OKAY);
    end
    $display("test registers done");
    for (int k = 0; k < 6; k++)
    begin
      for (int i = 0; i < 2; i++)
      begin
        d = $urandom() & 32'hFFFF_7FFF;
        if (k == 0 && i == 1)
          d[6:5] = 2'h0;
        axw(baddr[i], d, RESP_OKAY);
        cfg[i] = d & CFG_WMASK;
      end
      for (int j = 0; j < 8; j++)
      begin
        a = {1'b0, cfg[j / 4][31:19], 18'h0};
        n = 20 + cfg[j / 4][2:0];
        case (j % 4)
          0: a = $urandom();
          1: a = a + ($urandom() & ((32'h1 << n) - 1));
          2: a = a + (32'h1 << n) - 1;
          default: a = a + (32'h1 << n);
        endcase
        mem_chk(a);
      end
    end
    @(posedge aclk);
    mem_req <= 0;
    $display("test decode done");
    stall <= 2'h1;
    axw(ADDR_BANK0, cfg[0] | 32'h0000_8000, RESP_OKAY);
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    chk("mode0 held", 0, mode0);
    axr(ADDR_BANK0, cfg[0] | 32'h0000_8000, RESP_OKAY);
    d = {28'h0, (cfg[1][2:0] != 3'h0) && (cfg[1][6:5] != 2'h0),
         (cfg[0][2:0] != 3'h0) && (cfg[0][6:5] != 2'h0), 2'h1};
    axr(ADDR_STATUS, d, RESP_OKAY);
    stall <= 2'h0;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk("mode0", 1, mode0);
    chk("mode1", 0, mode1);
    axr(ADDR_BANK0, cfg[0], RESP_OKAY);
    axw(ADDR_BANK1, cfg[1] | 32'h0000_8000, RESP_OKAY);
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk("mode1", 1, mode1);
    chk("mode0 kept", 1, mode0);
    axr(ADDR_BANK1, cfg[1], RESP_OKAY);
    $display("test mode_set done");
    n = 3 + ($urandom() % 6);
    axw(ADDR_REFRESH, (n << 3) | 1, RESP_OKAY);
    axr(ADDR_REFRESH, (n << 3) | 1, RESP_OKAY);
    repeat (4 * n + 2) @(posedge aclk);
    chk("refresh gap", n, gap);
    chk("refresh bank1", 0, ref1);
    axw(ADDR_REFRESH, 32'h0, RESP_OKAY);
    axw(ADDR_REFRESH, (n << 3) | 2, RESP_OKAY);
    repeat (2 * n) @(posedge aclk);
    @(negedge aclk);
    chk("refresh bank1 on", 2, ref1);
    axw(ADDR_REFRESH, 32'h0, RESP_OKAY);
    $display("test refresh done");
    conclude();
  end
endmodule // sbc_top_tb
`default_nettype wire
